// ---- core/gsp_top.sv ----
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "gsp_map.svh"
// Behaviour
// R1: reset low returns all state except the source-select synchroniser to defaults, held as long as reset low
// R2: host holds reset low at least two clocks once clock is valid
// R3: source-select pin level captured into external switch mode at release
// R4: after release, when enabled, pin picks pair 3/5 or pair 4/6
// R5: rate-family pin level loads rate default and both digital output families
// R6: after release rate-family pin is gpio with direction, value and state
// R7: ref-fail pin follows latched ref-fail bit when enabled, else floats
// R8: lock pin shows main dpll lock when enabled, else driven low
// R9: function select: 0 interrupt request (default), 1 loss of reference
// R10: interrupt mode has polarity, push-pull or open-drain, and gpo option
// R11: loss mode drives live activity monitor of the selected reference
// R12: source-select pin passes a two-stage synchroniser before use
module gsp_top (
   input wire logic ref_clk, // 250 MHz master clock
   input wire logic resetn, // sync reset, low active
   input wire logic [7:0] paddr, // apb address
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb unmapped address
   input wire logic fast_source_select_pin, // source-select pin
   input wire logic gp4_i, // rate-family/gpio pin level
   output gsp_pkg::gsp_pin_type gp4_pin, // rate-family/gpio drive
   input wire logic ref_act_bad, // live monitor of selected ref
   input wire logic dpll_locked, // main dpll lock state
   output logic src_pair_sel, // 0 pair 3/5, 1 pair 4/6
   output logic ext_switch_mode, // external switch mode bit
   output logic rate_family, // 0 2.048 MHz, 1 1.544 MHz
   output logic dig1_rate_family, // digital output 1 family
   output logic dig2_rate_family, // digital output 2 family
   output gsp_pkg::gsp_pin_type ref_fail_pin, // ref-fail pin drive
   output logic lock_pin, // lock pin
   output gsp_pkg::gsp_pin_type irq_pin, // irq/loss pin drive
   output logic irq // level interrupt
);

   gsp_pkg::gsp_phase_type phase_q;
   logic src_s1_q;
   logic src_s2_q;
   logic release_ev;
   logic ctl_ext_mode_q;
   logic ctl_rfpin_q;
   logic ctl_lock_en_q;
   logic ctl_func_q;
   logic ctl_rate_q;
   logic ctl_dig1_q;
   logic ctl_dig2_q;
   gsp_pkg::gsp_irqcfg_type cfg_q;
   logic gp_dir_q;
   logic gp_out_q;
   logic gp_state_q;
   logic ref_fail_q;
   logic act_prev_q;
   logic lock_prev_q;
   logic [`GSP_NEV-1:0] ev;
   logic [`GSP_NEV-1:0] istat_q;
   logic [`GSP_NEV-1:0] ien_q;
   logic [`GSP_NEV-1:0] iclr;
   logic src_sel_q;
   logic irq_q;
   logic irq_lvl;
   logic pin_lvl;
   logic lock_pin_q;
   gsp_pkg::gsp_pin_type rf_pin_q;
   gsp_pkg::gsp_pin_type irq_pin_q;
   gsp_pkg::gsp_pin_type gp4_q;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic acc_first;
   logic wr_en;
   logic hit;
   logic [31:0] rd_d;

   // R12: synchroniser
   // left without reset so the pin is already settled when reset releases
   always_ff @(posedge ref_clk) begin
      src_s1_q <= fast_source_select_pin;
      src_s2_q <= src_s1_q;
   end

   // R1: reset phase
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         phase_q <= gsp_pkg::GSP_HELD;
      end else begin
         phase_q <= gsp_pkg::GSP_RUN;
      end
   end

   // first edge after the release; straps are caught here, not under reset
   assign release_ev = resetn && (phase_q == gsp_pkg::GSP_HELD);

   // apb: one wait state, effects at the edge that samples pready high
   assign acc_first = psel && penable && !pready_q;
   assign wr_en = psel && penable && pready_q && pwrite;
   assign iclr = (wr_en && paddr == `GSP_A_ICLR) ? pwdata[`GSP_NEV-1:0] : '0;

   always_comb begin
      rd_d = 32'h0;
      hit = 1'b1;
      if (paddr == `GSP_A_CTRL) begin
         rd_d[`GSP_C_EXTMODE] = ctl_ext_mode_q;
         rd_d[`GSP_C_RFPIN] = ctl_rfpin_q;
         rd_d[`GSP_C_LOCKEN] = ctl_lock_en_q;
         rd_d[`GSP_C_FUNC] = ctl_func_q;
         rd_d[`GSP_C_RATE] = ctl_rate_q;
         rd_d[`GSP_C_DIG1] = ctl_dig1_q;
         rd_d[`GSP_C_DIG2] = ctl_dig2_q;
      end else if (paddr == `GSP_A_IRQCFG) begin
         rd_d[`GSP_IRQCFG_W-1:0] = cfg_q;
      end else if (paddr == `GSP_A_GPIO) begin
         rd_d[`GSP_G_DIR] = gp_dir_q;
         rd_d[`GSP_G_OUT] = gp_out_q;
         rd_d[`GSP_G_PIN] = gp_state_q;
      end else if (paddr == `GSP_A_STATUS) begin
         rd_d[`GSP_S_RFAIL] = ref_fail_q;
         rd_d[`GSP_S_LOCK] = dpll_locked;
         rd_d[`GSP_S_LOSS] = ref_act_bad;
         rd_d[`GSP_S_SRC] = src_sel_q;
      end else if (paddr == `GSP_A_ISTAT) begin
         rd_d[`GSP_NEV-1:0] = istat_q;
      end else if (paddr == `GSP_A_IEN) begin
         rd_d[`GSP_NEV-1:0] = ien_q;
      end else if (paddr != `GSP_A_ICLR) begin
         hit = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0;
      end else begin
         pready_q <= acc_first;
         pslverr_q <= acc_first && !hit;
         if (acc_first && !pwrite) begin
            prdata_q <= rd_d;
         end
      end
   end

   // R3: strap and control
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         ctl_ext_mode_q <= 1'b0;
         ctl_rfpin_q <= 1'b0;
         ctl_lock_en_q <= 1'b0;
         ctl_func_q <= 1'b0;
         ctl_rate_q <= 1'b0;
         ctl_dig1_q <= 1'b0;
         ctl_dig2_q <= 1'b0;
      end else if (release_ev) begin
         ctl_ext_mode_q <= src_s2_q;
         // R5: rate family strap
         ctl_rate_q <= gp4_i;
         ctl_dig1_q <= gp4_i;
         ctl_dig2_q <= gp4_i;
      end else if (wr_en && paddr == `GSP_A_CTRL) begin
         ctl_ext_mode_q <= pwdata[`GSP_C_EXTMODE];
         ctl_rfpin_q <= pwdata[`GSP_C_RFPIN];
         ctl_lock_en_q <= pwdata[`GSP_C_LOCKEN];
         ctl_func_q <= pwdata[`GSP_C_FUNC];
         ctl_rate_q <= pwdata[`GSP_C_RATE];
         ctl_dig1_q <= pwdata[`GSP_C_DIG1];
         ctl_dig2_q <= pwdata[`GSP_C_DIG2];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         cfg_q <= `GSP_IRQCFG_RST;
         gp_dir_q <= 1'b0;
         gp_out_q <= 1'b0;
         ien_q <= `GSP_IEN_RST;
      end else if (wr_en && paddr == `GSP_A_IRQCFG) begin
         cfg_q <= pwdata[`GSP_IRQCFG_W-1:0];
      end else if (wr_en && paddr == `GSP_A_GPIO) begin
         gp_dir_q <= pwdata[`GSP_G_DIR];
         gp_out_q <= pwdata[`GSP_G_OUT];
      end else if (wr_en && paddr == `GSP_A_IEN) begin
         ien_q <= pwdata[`GSP_NEV-1:0];
      end
   end

   // R4: reference pair select
   // outside external switch mode the pair stays at 3/5
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         src_sel_q <= 1'b0;
      end else if (phase_q == gsp_pkg::GSP_RUN && ctl_ext_mode_q) begin
         src_sel_q <= src_s2_q;
      end else begin
         src_sel_q <= 1'b0;
      end
   end

   // R6: gpio pin; input until software turns it round, strap stays readable
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         gp_state_q <= 1'b0;
         gp4_q <= '{o: 1'b0, oe_n: 1'b1};
      end else begin
         gp_state_q <= gp4_i;
         gp4_q.o <= gp_out_q;
         gp4_q.oe_n <= !(gp_dir_q && phase_q == gsp_pkg::GSP_RUN);
      end
   end

   // latched ref-fail: a new failure in the clearing cycle keeps the bit set
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         ref_fail_q <= 1'b0;
         act_prev_q <= 1'b0;
         lock_prev_q <= 1'b0;
      end else begin
         act_prev_q <= ref_act_bad;
         lock_prev_q <= dpll_locked;
         if (ref_act_bad) begin
            ref_fail_q <= 1'b1;
         end else if (wr_en && paddr == `GSP_A_STATUS && pwdata[`GSP_S_RFAIL]) begin
            ref_fail_q <= 1'b0;
         end
      end
   end

   assign ev[`GSP_E_RFAIL] = ref_act_bad && !ref_fail_q;
   assign ev[`GSP_E_UNLOCK] = lock_prev_q && !dpll_locked;
   assign ev[`GSP_E_LOSS] = ref_act_bad && !act_prev_q;

   // sticky status, set beats clear
   genvar gi;
   generate
      for (gi = 0; gi < `GSP_NEV; gi = gi + 1) begin : g_stat
         always_ff @(posedge ref_clk) begin
            if (!resetn) begin
               istat_q[gi] <= 1'b0;
            end else if (ev[gi]) begin
               istat_q[gi] <= 1'b1;
            end else if (iclr[gi]) begin
               istat_q[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   assign irq_lvl = |(istat_q & ien_q);

   // R10: asserted level, polarity or gpo value
   assign pin_lvl = cfg_q.gpo ? cfg_q.gpo_val : (irq_lvl ~^ cfg_q.pol_hi);

   // status pins
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         irq_q <= 1'b0;
         lock_pin_q <= 1'b0;
         rf_pin_q <= '{o: 1'b0, oe_n: 1'b1};
         irq_pin_q <= '{o: 1'b0, oe_n: 1'b1};
      end else begin
         irq_q <= irq_lvl;
         // R8: lock pin
         lock_pin_q <= ctl_lock_en_q && dpll_locked;
         // R7: ref-fail pin
         rf_pin_q.o <= ref_fail_q;
         rf_pin_q.oe_n <= !ctl_rfpin_q;
         // R9: pin function
         if (ctl_func_q) begin
            // R11: live loss of reference
            irq_pin_q <= '{o: ref_act_bad, oe_n: 1'b0};
         end else if (cfg_q.od) begin
            // open drain only ever pulls low
            irq_pin_q <= '{o: 1'b0, oe_n: pin_lvl};
         end else begin
            irq_pin_q <= '{o: pin_lvl, oe_n: 1'b0};
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign gp4_pin = gp4_q;
   assign src_pair_sel = src_sel_q;
   assign ext_switch_mode = ctl_ext_mode_q;
   assign rate_family = ctl_rate_q;
   assign dig1_rate_family = ctl_dig1_q;
   assign dig2_rate_family = ctl_dig2_q;
   assign ref_fail_pin = rf_pin_q;
   assign lock_pin = lock_pin_q;
   assign irq_pin = irq_pin_q;
   assign irq = irq_q;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);

   // R1: reset clears
   reset_clears_a: assert property (disable iff (1'b0) !resetn |=> // R1
      (!lock_pin && !irq && istat_q == '0 && rf_pin_q.oe_n && !pready))
      else $error("state not cleared under reset");

   // R3: strap capture
   strap_capture_a: assert property (release_ev |=> // R3
      ext_switch_mode == $past(src_s2_q))
      else $error("switch mode strap not captured");

   // R4: pair select
   pair_select_a: assert property (ctl_ext_mode_q && phase_q == gsp_pkg::GSP_RUN // R4
      |=> src_pair_sel == $past(src_s2_q))
      else $error("reference pair not following pin");

   // R5: rate strap
   rate_strap_a: assert property (release_ev |=> // R5
      rate_family == $past(gp4_i) && dig1_rate_family == $past(gp4_i)
      && dig2_rate_family == $past(gp4_i))
      else $error("rate family strap not captured");

   // R6: gpio drive
   gpio_drive_a: assert property (phase_q == gsp_pkg::GSP_RUN && gp_dir_q // R6
      |=> !gp4_pin.oe_n && gp4_pin.o == $past(gp_out_q))
      else $error("gpio not driving its value");

   // R7: ref-fail pin
   ref_fail_pin_a: assert property (1'b1 |=> // R7
      ref_fail_pin.oe_n == !$past(ctl_rfpin_q)
      && ref_fail_pin.o == $past(ref_fail_q))
      else $error("ref-fail pin wrong");

   // R8: lock pin
   lock_pin_a: assert property (!ctl_lock_en_q ##1 !ctl_lock_en_q |=> !lock_pin) // R8
      else $error("lock pin not low when disabled");

   // R10: interrupt push-pull
   irq_pushpull_a: assert property (!ctl_func_q && !cfg_q.od && !cfg_q.gpo // R10
      |=> !irq_pin.oe_n && irq_pin.o == ($past(irq_lvl) ~^ $past(cfg_q.pol_hi)))
      else $error("interrupt pin level wrong");

   // R11: loss mode
   loss_mode_a: assert property (ctl_func_q |=> // R11
      !irq_pin.oe_n && irq_pin.o == $past(ref_act_bad))
      else $error("loss pin not live");

   // R12: sync depth
   sync_depth_a: assert property (phase_q == gsp_pkg::GSP_RUN |-> // R12
      src_s2_q == $past(fast_source_select_pin, 2))
      else $error("synchroniser depth wrong");

   ext_switch_c: cover property (ctl_ext_mode_q && src_s2_q ##1 src_pair_sel);
   loss_mode_c: cover property (ctl_func_q && ref_act_bad ##1 irq_pin.o);
   irq_fire_c: cover property (ev[`GSP_E_UNLOCK] ##[1:3] irq);

endmodule : gsp_top

// ---- core/gsp_map.svh ----
`ifndef GSP_MAP_SVH
`define GSP_MAP_SVH

// register byte offsets
`define GSP_A_CTRL 8'h00
`define GSP_A_IRQCFG 8'h04
`define GSP_A_GPIO 8'h08
`define GSP_A_STATUS 8'h0c
`define GSP_A_ISTAT 8'h10
`define GSP_A_ICLR 8'h14
`define GSP_A_IEN 8'h18

// control register fields
`define GSP_C_EXTMODE 0
`define GSP_C_RFPIN 1
`define GSP_C_LOCKEN 2
`define GSP_C_FUNC 3
`define GSP_C_RATE 4
`define GSP_C_DIG1 5
`define GSP_C_DIG2 6

// gpio register fields
`define GSP_G_DIR 0
`define GSP_G_OUT 1
`define GSP_G_PIN 2

// status register fields
`define GSP_S_RFAIL 0
`define GSP_S_LOCK 1
`define GSP_S_LOSS 2
`define GSP_S_SRC 3

// interrupt event bits
`define GSP_NEV 3
`define GSP_E_RFAIL 0
`define GSP_E_UNLOCK 1
`define GSP_E_LOSS 2

// width of the shared pin config field
`define GSP_IRQCFG_W 4
`define GSP_IRQCFG_RST 4'h1
`define GSP_IEN_RST 3'h0

`endif

// ---- core/gsp_pkg.sv ----
package gsp_pkg;

   // two-signal view of a pin the device may float
   typedef struct packed {
      logic o;
      logic oe_n;
   } gsp_pin_type;

   // shared pin config: gpo level, gpo mode, open drain, active high
   typedef struct packed {
      logic gpo_val;
      logic gpo;
      logic od;
      logic pol_hi;
   } gsp_irqcfg_type;

   typedef enum logic {
      GSP_HELD = 1'b0,
      GSP_RUN = 1'b1
   } gsp_phase_type;

endpackage : gsp_pkg

// ---- tb/gsp_sys_model.sv ----
`timescale 1ns/1ps
module gsp_sys_model (
   input wire logic src_lvl, // source-select level to present
   input wire logic rate_lvl, // level of the outside rate-pin driver
   input wire logic rate_drv, // outside rate-pin driver active
   input wire logic lock_lvl, // dpll lock state
   input wire logic bad_lvl, // activity monitor failure
   input wire gsp_pkg::gsp_pin_type gp4_pin, // device drive of rate pin
   output logic fast_source_select_pin, // to device
   output logic gp4_i, // resolved rate-pin level
   output logic dpll_locked, // to device
   output logic ref_act_bad // to device
);
   // straps stay put while reset is low
   assign fast_source_select_pin = src_lvl;
   // released pin falls to its pull-down, never keeps a stale level
   assign gp4_i = !gp4_pin.oe_n ? gp4_pin.o : (rate_drv ? rate_lvl : 1'b0);
   assign dpll_locked = lock_lvl;
   assign ref_act_bad = bad_lvl;
endmodule : gsp_sys_model

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`include "gsp_map.svh"
module testbench;
   logic ref_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, e;
   logic src_lvl = 1, rate_lvl = 1, rate_drv = 1, lock_lvl = 1, bad_lvl = 0;
   logic fast_source_select_pin, gp4_i, ref_act_bad, dpll_locked, irq, lock_pin;
   logic src_pair_sel, ext_switch_mode, rate_family, dig1_rate_family, dig2_rate_family;
   gsp_pkg::gsp_pin_type gp4_pin, ref_fail_pin, irq_pin;
   int error_cnt = 0, checks_done = 0;

   always #2 ref_clk = ~ref_clk;

   gsp_top i_gsp_top (.ref_clk, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata,
      .prdata, .pready, .pslverr, .fast_source_select_pin, .gp4_i, .gp4_pin,
      .ref_act_bad, .dpll_locked, .src_pair_sel, .ext_switch_mode, .rate_family,
      .dig1_rate_family, .dig2_rate_family, .ref_fail_pin, .lock_pin, .irq_pin, .irq);

   gsp_sys_model i_gsp_sys_model (.src_lvl, .rate_lvl, .rate_drv, .lock_lvl, .bad_lvl,
      .gp4_pin, .fast_source_select_pin, .gp4_i, .dpll_locked, .ref_act_bad);

   task print_verdict;
      if (error_cnt == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : print_verdict

   task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      checks_done++;
      if (s !== x) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, x, s);
      end
   endtask : chk

   task cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : cyc

   // request held until pready is seen high at a rising edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
      if (pready !== 1'b1) begin
         chk("pready", pready, 1);
         print_verdict();
      end
   endtask : apb

   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1, a, d);
   endtask : wr

   task rdc(input string nm, input logic [7:0] a, input logic [31:0] x);
      apb(0, a, 32'h0);
      chk(nm, rd, x);
   endtask : rdc

   task t_straps;
      chk("ext_switch_mode", ext_switch_mode, 1);
      chk("rate_families", {dig2_rate_family, dig1_rate_family, rate_family}, 3'h7);
      rdc("ctrl", `GSP_A_CTRL, 32'h71);
      rdc("irqcfg", `GSP_A_IRQCFG, 32'h1);
      rdc("ien", `GSP_A_IEN, 32'h0);
   endtask : t_straps

   task t_src;
      chk("pair", src_pair_sel, 1);
      @(posedge ref_clk);
      src_lvl <= 0;
      cyc(2);
      chk("pair_sync", src_pair_sel, 1);
      cyc(1);
      chk("pair", src_pair_sel, 0);
      wr(`GSP_A_CTRL, 32'h70);
      @(posedge ref_clk);
      src_lvl <= 1;
      cyc(5);
      chk("pair_off", src_pair_sel, 0);
      rdc("status", `GSP_A_STATUS, 32'h2);
   endtask : t_src

   task t_lock;
      wr(`GSP_A_CTRL, 32'h74);
      cyc(2);
      chk("lock_pin", lock_pin, 1);
      @(posedge ref_clk);
      lock_lvl <= 0;
      cyc(2);
      chk("lock_pin", lock_pin, 0);
      @(posedge ref_clk);
      lock_lvl <= 1;
      wr(`GSP_A_CTRL, 32'h70);
      cyc(2);
      chk("lock_pin_off", lock_pin, 0);
   endtask : t_lock

   task t_fail;
      wr(`GSP_A_CTRL, 32'h72);
      @(posedge ref_clk);
      bad_lvl <= 1;
      cyc(2);
      @(posedge ref_clk);
      bad_lvl <= 0;
      cyc(2);
      // latched failure outlives the live monitor
      chk("ref_fail_pin", ref_fail_pin, 2'b10);
      rdc("status", `GSP_A_STATUS, 32'h3);
      // new failure and loss edge join the lock loss left from the lock scenario
      rdc("istat_fail", `GSP_A_ISTAT, 32'h7);
      wr(`GSP_A_STATUS, 32'h1);
      cyc(2);
      chk("ref_fail_pin", ref_fail_pin, 2'b00);
      wr(`GSP_A_CTRL, 32'h70);
      cyc(2);
      chk("ref_fail_float", ref_fail_pin.oe_n, 1);
   endtask : t_fail

   task t_irq;
      wr(`GSP_A_ICLR, 32'h7);
      rdc("istat", `GSP_A_ISTAT, 32'h0);
      wr(`GSP_A_IEN, 32'h2);
      @(posedge ref_clk);
      lock_lvl <= 0;
      cyc(3);
      chk("irq", irq, 1);
      chk("irq_pin", irq_pin, 2'b10);
      wr(`GSP_A_IEN, 32'h0);
      cyc(2);
      chk("irq_masked", irq, 0);
      rdc("istat", `GSP_A_ISTAT, 32'h2);
      wr(`GSP_A_IEN, 32'h2);
      wr(`GSP_A_IRQCFG, 32'h0);
      cyc(2);
      chk("irq_pin_low", irq_pin, 2'b00);
      wr(`GSP_A_IRQCFG, 32'h2);
      cyc(2);
      chk("irq_pin_od", irq_pin, 2'b00);
      wr(`GSP_A_ICLR, 32'h2);
      cyc(3);
      chk("irq_pin_od_rel", irq_pin.oe_n, 1);
      wr(`GSP_A_IRQCFG, 32'hc);
      cyc(2);
      chk("irq_pin_gpo", irq_pin, 2'b10);
      wr(`GSP_A_IRQCFG, 32'h4);
      cyc(2);
      chk("irq_pin_gpo", irq_pin, 2'b00);
      @(posedge ref_clk);
      lock_lvl <= 1;
   endtask : t_irq

   task t_loss;
      wr(`GSP_A_CTRL, 32'h78);
      @(posedge ref_clk);
      bad_lvl <= 1;
      cyc(2);
      chk("loss_pin", irq_pin, 2'b10);
      @(posedge ref_clk);
      bad_lvl <= 0;
      cyc(2);
      chk("loss_pin", irq_pin, 2'b00);
      wr(`GSP_A_CTRL, 32'h74);
   endtask : t_loss

   task t_gpio;
      wr(`GSP_A_GPIO, 32'h3);
      cyc(2);
      chk("gp4_pin", gp4_pin, 2'b10);
      rdc("gpio", `GSP_A_GPIO, 32'h7);
      wr(`GSP_A_GPIO, 32'h1);
      rdc("gpio", `GSP_A_GPIO, 32'h1);
      wr(`GSP_A_GPIO, 32'h0);
      @(posedge ref_clk);
      rate_drv <= 1;
      cyc(2);
      chk("gp4_float", gp4_pin.oe_n, 1);
      rdc("gpio_in", `GSP_A_GPIO, 32'h4);
      @(posedge ref_clk);
      rate_drv <= 0;
      rdc("gpio_in", `GSP_A_GPIO, 32'h0);
   endtask : t_gpio

   task t_map_reset;
      apb(0, 8'h1c, 32'h0);
      chk("pslverr", e, 1);
      rdc("iclr", `GSP_A_ICLR, 32'h0);
      @(posedge ref_clk);
      resetn <= 0;
      src_lvl <= 0;
      rate_lvl <= 0;
      rate_drv <= 1;
      cyc(3);
      chk("lock_pin_rst", lock_pin, 0);
      @(posedge ref_clk);
      resetn <= 1;
      @(posedge ref_clk);
      rate_drv <= 0;
      rdc("ctrl", `GSP_A_CTRL, 32'h0);
   endtask : t_map_reset

   initial begin
      // reset held well past two clocks
      repeat (19) @(posedge ref_clk);
      #1;
      chk("irq_pin_rst", irq_pin.oe_n, 1);
      chk("ref_fail_rst", ref_fail_pin.oe_n, 1);
      @(posedge ref_clk);
      resetn <= 1;
      @(posedge ref_clk);
      rate_drv <= 0;
      cyc(1);
      t_straps();
      t_src();
      t_lock();
      t_fail();
      t_irq();
      t_loss();
      t_gpio();
      t_map_reset();
      print_verdict();
   end
endmodule : testbench
